// >>> core/ivt_pkg.sv
// Shared constants and types for the interrupt vector and trap unit.
package ivt_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int IVT_ADDR_W    = 24;
  localparam int IVT_TRAPN_W   = 7;
  localparam int IVT_PRIO_W    = 4;
  localparam int IVT_NUM_NODES = 30;
  localparam int IVT_NUM_FLAGS = 8;
  localparam int IVT_SYNC_LEN  = 2;

  // ==========================================================================
  // Fixed trap numbers
  localparam logic [IVT_TRAPN_W-1:0] IVT_TN_RESET  = 7'h00;
  localparam logic [IVT_TRAPN_W-1:0] IVT_TN_NMI    = 7'h02;
  localparam logic [IVT_TRAPN_W-1:0] IVT_TN_STACK_OVERFLOW_FLAG  = 7'h04;
  localparam logic [IVT_TRAPN_W-1:0] IVT_TN_STACK_UNDERFLOW_FLAG  = 7'h06;
  localparam logic [IVT_TRAPN_W-1:0] IVT_TN_CLASSB = 7'h0A;

  // ==========================================================================
  // Bit positions in the trap flag register
  localparam int IVT_FLAG_NMI    = 0;
  localparam int IVT_FLAG_STACK_OVERFLOW_FLAG  = 1;
  localparam int IVT_FLAG_STACK_UNDERFLOW_FLAG  = 2;
  localparam int IVT_FLAG_UNDEFINED_OPCODE_FLAG = 3;
  localparam int IVT_FLAG_PROTECTED_INSTR_FAULT_FLAG = 4;
  localparam int IVT_FLAG_ILLEGAL_OPERAND_ACCESS_FLAG = 5;
  localparam int IVT_FLAG_ILLEGAL_INSTR_ACCESS_FLAG = 6;
  localparam int IVT_FLAG_ILLEGAL_BUS_ACCESS_FLAG = 7;
  localparam logic [IVT_NUM_FLAGS-1:0] IVT_CLASSB_MASK = 8'hF8;
  localparam logic [IVT_NUM_FLAGS-1:0] IVT_FLAGS_RST   = 8'h00;
  localparam logic [IVT_PRIO_W-1:0]    IVT_LEVEL_RST   = 4'h0;

  // ==========================================================================
  // Trap number of each interrupt node, by node index
  localparam logic [IVT_TRAPN_W-1:0] IVT_NODE_TRAP [0:IVT_NUM_NODES-1] = '{
    7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F,
    7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29,
    7'h2A, 7'h47, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F,
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46};

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    TL_NONE, TL_CLASS_B, TL_STK_UNDER, TL_STK_OVER, TL_NMI
  } ivt_trap_lvl_t;

  typedef struct packed {
    logic illegal_bus;
    logic illegal_instr;
    logic illegal_operand;
    logic prot_fault;
    logic undef_opcode;
    logic stack_under;
    logic stack_over;
  } ivt_fault_t;

  typedef struct packed {
    logic [IVT_ADDR_W-1:0]  vector;
    logic [IVT_TRAPN_W-1:0] trap_num;
  } ivt_branch_t;

  // Every vector sits at four times its trap number.
  function automatic logic [IVT_ADDR_W-1:0] ivt_vector_of(
    input logic [IVT_TRAPN_W-1:0] num);
    return {15'h0000, num, 2'b00};
  endfunction : ivt_vector_of

endpackage : ivt_pkg

// >>> core/ivt_node_bank.sv
// Per-node request, enable and priority registers with the node arbiter.
`timescale 1ns/1ps
module ivt_node_bank #(
  parameter int NODES  = 30,
  parameter int PRIO_W = 4
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic [NODES-1:0]  i_event,
  input  wire logic [NODES-1:0]  i_sw_set,
  input  wire logic [NODES-1:0]  i_sw_clear,
  input  wire logic [NODES-1:0]  i_ack,
  input  wire logic [NODES-1:0]  i_cfg_we,
  input  wire logic              i_cfg_enable,
  input  wire logic [PRIO_W-1:0] i_cfg_prio,
  output logic      [NODES-1:0]  o_request,
  output logic                   o_win_valid,
  output logic [$clog2(NODES)-1:0] o_win_idx,
  output logic      [PRIO_W-1:0] o_win_prio
);

  // ==========================================================================
  // Node control registers
  logic [NODES-1:0]  req_reg, req_next;
  logic [NODES-1:0]  en_reg, en_next;
  logic [PRIO_W-1:0] prio_reg  [NODES];
  logic [PRIO_W-1:0] prio_next [NODES];

  genvar g;
  generate
    for (g = 0; g < NODES; g++)
    begin : g_node
      // A new request wins over a clear in the same cycle.
      always_comb
      begin
        req_next[g]  = (req_reg[g] & ~i_sw_clear[g] & ~i_ack[g])
                     | i_event[g] | i_sw_set[g]; // see [RULE_08]
        en_next[g]   = i_cfg_we[g] ? i_cfg_enable : en_reg[g];
        prio_next[g] = i_cfg_we[g] ? i_cfg_prio : prio_reg[g];
      end
      always_ff @(posedge i_sys_clk)
      begin
        if (i_rst)
        begin
          req_reg[g]  <= 1'b0;
          en_reg[g]   <= 1'b0;
          prio_reg[g] <= '0;
        end
        else
        begin
          req_reg[g]  <= req_next[g];
          en_reg[g]   <= en_next[g];
          prio_reg[g] <= prio_next[g];
        end
      end
    end
  endgenerate

  assign o_request = req_reg;

  // ==========================================================================
  // Arbiter: highest level wins, lower index breaks a tie.
  always_comb
  begin
    o_win_valid = 1'b0;
    o_win_idx   = '0;
    o_win_prio  = '0;
    for (int i = 0; i < NODES; i++)
    begin
      if (req_reg[i] && en_reg[i] &&
          (!o_win_valid || prio_reg[i] > o_win_prio))
      begin
        o_win_valid = 1'b1;
        o_win_idx   = i[$clog2(NODES)-1:0];
        o_win_prio  = prio_reg[i];
      end
    end
  end

endmodule : ivt_node_bank

// >>> core/ivt_trap_unit.sv
// Trap and interrupt vectoring: trap flags, trap priority, branch request.
//
// Contract
// [RULE_01] Every node branches to four times its trap number, 47h to 11Ch.
// [RULE_02] A hardware trap branches to its vector at once, unmaskable.
// [RULE_03] Each hardware trap sets its own bit in the trap flag register.
// [RULE_04] A new trap waits only while a higher trap service is running; the code also waits while a trap of the same level runs.
// [RULE_05] No node service or event transfer is granted in a trap service.
// [RULE_06] NMI goes to 08h, stack overflow to 10h and stack underflow to 18h.
// [RULE_07] The five class B faults share vector 28h and differ only by flag.
// [RULE_08] Each node has request and enable flags and a 16-level priority.
// [RULE_09] An accepted service is only preempted by a strictly higher level.
// [RULE_10] A software trap branches to the vector of any given trap number.
// [RULE_11] Hardware, software and watchdog resets all go to vector 0.
`timescale 1ns/1ps
module ivt_trap_unit
  import ivt_pkg::*;
#(
  parameter int NODES = ivt_pkg::IVT_NUM_NODES
) (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_nmi_n,
  input  wire ivt_pkg::ivt_fault_t          i_faults,
  input  wire logic                         i_sw_reset,
  input  wire logic                         i_wdt_overflow,
  input  wire logic                         i_sw_trap_valid,
  input  wire logic [ivt_pkg::IVT_TRAPN_W-1:0] i_sw_trap_num,
  input  wire logic                         i_svc_return,
  input  wire logic [ivt_pkg::IVT_PRIO_W-1:0] i_ret_level,
  input  wire logic [ivt_pkg::IVT_NUM_FLAGS-1:0] i_flag_clear,
  input  wire logic [NODES-1:0]             i_node_event,
  input  wire logic [NODES-1:0]             i_node_sw_set,
  input  wire logic [NODES-1:0]             i_node_sw_clear,
  input  wire logic [NODES-1:0]             i_node_cfg_we,
  input  wire logic                         i_node_cfg_enable,
  input  wire logic [ivt_pkg::IVT_PRIO_W-1:0] i_node_cfg_prio,
  output logic                              o_branch_valid,
  output ivt_pkg::ivt_branch_t              o_branch,
  output logic [ivt_pkg::IVT_NUM_FLAGS-1:0] o_trap_flags,
  output logic                              o_trap_active,
  output logic [ivt_pkg::IVT_PRIO_W-1:0]    o_cpu_level,
  output logic [NODES-1:0]                  o_node_ack,
  output logic [NODES-1:0]                  o_node_request
);

  import ivt_pkg::*;

  localparam int IDX_W = $clog2(NODES);

  // ==========================================================================
  // NMI pin synchroniser and falling edge detect
  logic [IVT_SYNC_LEN-1:0] nmi_sync_reg;
  logic                    nmi_prev_reg;
  logic                    nmi_event;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      nmi_sync_reg <= '1;
      nmi_prev_reg <= 1'b1;
    end
    else
    begin
      nmi_sync_reg <= {nmi_sync_reg[IVT_SYNC_LEN-2:0], i_nmi_n};
      nmi_prev_reg <= nmi_sync_reg[IVT_SYNC_LEN-1];
    end
  end

  assign nmi_event = nmi_prev_reg & ~nmi_sync_reg[IVT_SYNC_LEN-1];

  // ==========================================================================
  // Node bank
  logic [NODES-1:0]      ack_next;
  logic                  win_valid;
  logic [IDX_W-1:0]      win_idx;
  logic [IVT_PRIO_W-1:0] win_prio;

  ivt_node_bank #(
    .NODES  (NODES),
    .PRIO_W (IVT_PRIO_W)
  ) u_node_bank (
    .i_sys_clk    (i_sys_clk),
    .i_rst        (i_rst),
    .i_event      (i_node_event),
    .i_sw_set     (i_node_sw_set),
    .i_sw_clear   (i_node_sw_clear),
    .i_ack        (ack_next),
    .i_cfg_we     (i_node_cfg_we),
    .i_cfg_enable (i_node_cfg_enable),
    .i_cfg_prio   (i_node_cfg_prio),
    .o_request    (o_node_request),
    .o_win_valid  (win_valid),
    .o_win_idx    (win_idx),
    .o_win_prio   (win_prio)
  );

  // ==========================================================================
  // Trap and branch state
  logic [IVT_NUM_FLAGS-1:0] flags_reg, flags_next;
  logic [IVT_NUM_FLAGS-1:0] pend_reg, pend_next;
  logic [IVT_NUM_FLAGS-1:0] fault_vec, pend_all, take_mask;
  ivt_trap_lvl_t            lvl_reg, lvl_next, cand_lvl;
  logic [IVT_TRAPN_W-1:0]   cand_num;
  logic [IVT_PRIO_W-1:0]    level_reg, level_next;
  logic                     boot_reg, boot_next;
  logic                     swp_reg, swp_next;
  logic [IVT_TRAPN_W-1:0]   swn_reg, swn_next;
  logic                     br_valid_next;
  logic [IVT_TRAPN_W-1:0]   br_num_next;
  logic                     rst_evt, hw_take, sw_req;
  logic [IVT_TRAPN_W-1:0]   sw_num;

  assign fault_vec = {i_faults, nmi_event};
  assign rst_evt   = boot_reg | i_sw_reset | i_wdt_overflow;
  assign sw_req    = swp_reg | i_sw_trap_valid;
  assign sw_num    = swp_reg ? swn_reg : i_sw_trap_num;

  always_comb
  begin
    pend_all  = pend_reg | fault_vec;
    cand_lvl  = TL_NONE;
    cand_num  = IVT_TN_RESET;
    take_mask = '0;
    if (pend_all[IVT_FLAG_NMI])
    begin
      cand_lvl  = TL_NMI;
      cand_num  = IVT_TN_NMI; // see [RULE_06]
      take_mask[IVT_FLAG_NMI] = 1'b1;
    end
    else if (pend_all[IVT_FLAG_STACK_OVERFLOW_FLAG])
    begin
      cand_lvl  = TL_STK_OVER;
      cand_num  = IVT_TN_STACK_OVERFLOW_FLAG; // see [RULE_06]
      take_mask[IVT_FLAG_STACK_OVERFLOW_FLAG] = 1'b1;
    end
    else if (pend_all[IVT_FLAG_STACK_UNDERFLOW_FLAG])
    begin
      cand_lvl  = TL_STK_UNDER;
      cand_num  = IVT_TN_STACK_UNDERFLOW_FLAG; // see [RULE_06]
      take_mask[IVT_FLAG_STACK_UNDERFLOW_FLAG] = 1'b1;
    end
    else if (|(pend_all & IVT_CLASSB_MASK))
    begin
      cand_lvl  = TL_CLASS_B;
      cand_num  = IVT_TN_CLASSB; // see [RULE_07]
      take_mask = IVT_CLASSB_MASK;
    end
  end

  // No enable gates this: the only wait is behind an equal or higher trap level.
  assign hw_take = (cand_lvl > lvl_reg); // see [RULE_02] see [RULE_04]

  always_comb
  begin
    // A fault in the same cycle as its clear leaves the flag set.
    flags_next    = (flags_reg & ~i_flag_clear) | fault_vec; // see [RULE_03]
    pend_next     = pend_all;
    lvl_next      = lvl_reg;
    level_next    = level_reg;
    boot_next     = 1'b0;
    swp_next      = 1'b0;
    swn_next      = swn_reg;
    ack_next      = '0;
    br_valid_next = 1'b0;
    br_num_next   = IVT_TN_RESET;
    if (i_svc_return)
    begin
      if (lvl_reg != TL_NONE)
        lvl_next = TL_NONE;
      else
        level_next = i_ret_level;
    end
    if (rst_evt)
    begin
      br_valid_next = 1'b1; // see [RULE_11]
      pend_next     = '0;
      lvl_next      = TL_NONE;
      level_next    = IVT_LEVEL_RST;
    end
    else if (hw_take)
    begin
      br_valid_next = 1'b1;
      br_num_next   = cand_num;
      pend_next     = pend_all & ~take_mask;
      lvl_next      = cand_lvl;
      // A software trap colliding with a hardware trap is held, not lost.
      swp_next      = sw_req;
      swn_next      = sw_num;
    end
    else if (sw_req)
    begin
      br_valid_next = 1'b1;
      br_num_next   = sw_num; // see [RULE_10]
    end
    else if (lvl_reg == TL_NONE && win_valid && win_prio > level_reg)
    begin
      // Trap services lock out node services: nodes branch only at trap level TL_NONE.
      br_valid_next     = 1'b1; // see [RULE_05] see [RULE_09]
      br_num_next       = IVT_NODE_TRAP[win_idx]; // see [RULE_01]
      ack_next[win_idx] = 1'b1;
      level_next        = win_prio;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      flags_reg      <= IVT_FLAGS_RST;
      pend_reg       <= '0;
      lvl_reg        <= TL_NONE;
      level_reg      <= IVT_LEVEL_RST;
      boot_reg       <= 1'b1;
      swp_reg        <= 1'b0;
      swn_reg        <= '0;
      o_branch_valid <= 1'b0;
      o_branch       <= '0;
      o_node_ack     <= '0;
      o_trap_active  <= 1'b0;
    end
    else
    begin
      flags_reg      <= flags_next;
      pend_reg       <= pend_next;
      lvl_reg        <= lvl_next;
      level_reg      <= level_next;
      boot_reg       <= boot_next;
      swp_reg        <= swp_next;
      swn_reg        <= swn_next;
      o_branch_valid <= br_valid_next;
      o_branch       <= '{vector: ivt_vector_of(br_num_next),
                          trap_num: br_num_next};
      o_node_ack     <= ack_next;
      o_trap_active  <= (lvl_next != TL_NONE);
    end
  end

  assign o_trap_flags = flags_reg;
  assign o_cpu_level  = level_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_branch_to(logic [IVT_ADDR_W-1:0] v);
    o_branch_valid && o_branch.vector == v;
  endsequence

  property p_vec_x4;
    o_branch_valid |-> o_branch.vector[1:0] == 2'b00 &&
      o_branch.vector[8:2] == o_branch.trap_num;
  endproperty
  a_vec_x4: assert property (p_vec_x4) // see [RULE_01]
    else $error("vector is not four times trap number");

  property p_nmi_now;
    (nmi_event && !rst_evt && lvl_reg != TL_NMI) |=> s_branch_to(24'h000008);
  endproperty
  a_nmi_now: assert property (p_nmi_now) // see [RULE_02]
    else $error("NMI did not branch to 08h next cycle");

  property p_flag_set;
    (|fault_vec) |=> ((o_trap_flags & $past(fault_vec)) == $past(fault_vec));
  endproperty
  a_flag_set: assert property (p_flag_set) // see [RULE_03]
    else $error("trap flag not set by its fault");

  property p_wait_higher;
    (lvl_reg == TL_NMI && i_faults.stack_over && !i_svc_return && !rst_evt)
      |=> !(o_branch_valid && o_branch.trap_num == IVT_TN_STACK_OVERFLOW_FLAG);
  endproperty
  a_wait_higher: assert property (p_wait_higher) // see [RULE_04]
    else $error("stack trap preempted NMI service");

  property p_no_node_in_trap;
    o_trap_active && !i_svc_return |=> o_node_ack == '0;
  endproperty
  a_no_node_in_trap: assert property (p_no_node_in_trap) // see [RULE_05]
    else $error("node granted during trap service");

  property p_stack_underflow_flag_vec;
    o_branch_valid && o_branch.trap_num == IVT_TN_STACK_UNDERFLOW_FLAG
      |-> o_branch.vector == 24'h000018 && o_trap_active;
  endproperty
  a_stack_underflow_flag_vec: assert property (p_stack_underflow_flag_vec) // see [RULE_06]
    else $error("stack underflow vector wrong");

  property p_classb;
    (|(fault_vec & IVT_CLASSB_MASK) && lvl_reg == TL_NONE && !rst_evt &&
     !(|(pend_all & ~IVT_CLASSB_MASK))) |=> s_branch_to(24'h000028);
  endproperty
  a_classb: assert property (p_classb) // see [RULE_07]
    else $error("class B fault did not branch to 28h");

  property p_strict_higher;
    (|ack_next) |-> win_prio > level_reg ##1 o_cpu_level == $past(win_prio);
  endproperty
  a_strict_higher: assert property (p_strict_higher) // see [RULE_09]
    else $error("node accepted without strictly higher level");

  property p_sw_trap;
    (i_sw_trap_valid && !swp_reg && !rst_evt && !hw_take)
      |=> o_branch_valid && o_branch.trap_num == $past(i_sw_trap_num);
  endproperty
  a_sw_trap: assert property (p_sw_trap) // see [RULE_10]
    else $error("software trap number not branched to");

  property p_reset_vec;
    (i_sw_reset || i_wdt_overflow) |=> s_branch_to(24'h000000) ##1
      !o_trap_active;
  endproperty
  a_reset_vec: assert property (p_reset_vec) // see [RULE_11]
    else $error("reset event did not branch to vector 0");

endmodule : ivt_trap_unit

// >>> tb/ivt_cpu_model.sv
// CPU-side model that ends each service it was branched into.
`timescale 1ns/1ps
// ============================================================
// Service return model
module ivt_cpu_model (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_branch_valid,
  input  wire logic i_ret_en,
  input  wire logic i_slow,
  output logic      o_svc_return
);
  logic [3:0] depth_reg;
  logic [3:0] depth_next;
  logic [2:0] wait_reg;
  logic [2:0] wait_next;
  logic       ret_next;

  // Services are counted, not stacked, so a return always ends the newest.
  always_comb
  begin
    ret_next   = 1'b0;
    wait_next  = 3'h0;
    depth_next = depth_reg + {3'h0, i_branch_valid};
    if (i_ret_en && depth_reg != 4'h0)
    begin
      wait_next = wait_reg + 3'h1;
      if (wait_reg >= (i_slow ? 3'h6 : 3'h1))
      begin
        ret_next   = 1'b1;
        wait_next  = 3'h0;
        depth_next = depth_next - 4'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      depth_reg    <= 4'h0;
      wait_reg     <= 3'h0;
      o_svc_return <= 1'b0;
    end
    else
    begin
      depth_reg    <= depth_next;
      wait_reg     <= wait_next;
      o_svc_return <= ret_next;
    end
  end
endmodule : ivt_cpu_model

// >>> tb/tb.sv
// Self-checking testbench for the trap and vector unit.
`timescale 1ns/1ps
// ============================================================
// Bench
module tb;
  import ivt_pkg::*;
  typedef struct {
    int idx; logic [3:0] prio; logic [23:0] vec; logic [6:0] tn;
  } ivt_row_t;
  ivt_row_t    rows [4] = '{'{0, 4'h1, 24'h000060, 7'h18},
    '{3, 4'h5, 24'h00006C, 7'h1B}, '{17, 4'hF, 24'h00011C, 7'h47},
    '{29, 4'h2, 24'h000118, 7'h46}};
  logic [6:0]  nums [4] = '{7'h00, 7'h7F, 7'h47, 7'h15};
  logic        clk, rst, nmi_n, sw_reset, wdt, swt_valid;
  logic        svc_ret, ret_en, slow, cfg_en, br_valid, tact;
  ivt_fault_t  faults;
  ivt_branch_t br;
  logic [6:0]  swt_num;
  logic [3:0]  ret_level, cfg_prio, lvl;
  logic [7:0]  flag_clr, flags;
  logic [29:0] ev, sset, sclr, cfg_we, ack, req;
  logic [23:0] v;
  int          error_cnt, cmp_count;

  ivt_trap_unit dut_u (.i_sys_clk(clk), .i_rst(rst), .i_nmi_n(nmi_n),
    .i_faults(faults), .i_sw_reset(sw_reset), .i_wdt_overflow(wdt),
    .i_sw_trap_valid(swt_valid), .i_sw_trap_num(swt_num),
    .i_svc_return(svc_ret), .i_ret_level(ret_level),
    .i_flag_clear(flag_clr), .i_node_event(ev), .i_node_sw_set(sset),
    .i_node_sw_clear(sclr), .i_node_cfg_we(cfg_we),
    .i_node_cfg_enable(cfg_en), .i_node_cfg_prio(cfg_prio),
    .o_branch_valid(br_valid), .o_branch(br), .o_trap_flags(flags),
    .o_trap_active(tact), .o_cpu_level(lvl), .o_node_ack(ack),
    .o_node_request(req));
  ivt_cpu_model cpu_u (.i_sys_clk(clk), .i_rst(rst),
    .i_branch_valid(br_valid), .i_ret_en(ret_en), .i_slow(slow),
    .o_svc_return(svc_ret));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ============================================================
  // Tasks
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Drops every one-cycle request so no pulse lasts past its edge.
  task clr();
    faults = '0; ev = '0; sset = '0; sclr = '0; cfg_we = '0;
    swt_valid = 1'b0; sw_reset = 1'b0; wdt = 1'b0; flag_clr = 8'h00;
  endtask : clr

  task wbr(input logic [23:0] vec, input logic [6:0] tn);
    int k;
    k = 0;
    @(negedge clk);
    clr();
    while (br_valid !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    chk(br_valid, 1'b1);
    chk(br.vector, vec);
    chk(br.trap_num, tn);
  endtask : wbr

  task nob(input int n);
    repeat (n)
    begin
      @(negedge clk);
      clr();
      chk(br_valid, 1'b0);
    end
  endtask : nob

  task cfg(input int i, input logic en, input logic [3:0] p);
    cfg_we[i] = 1'b1;
    cfg_en = en;
    cfg_prio = p;
    @(negedge clk);
    clr();
  endtask : cfg

  task stop_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    #(5000 * 8);
    error_cnt++;
    stop_test();
  end

  // ============================================================
  // Main sequence
  initial
  begin
    error_cnt = 0; cmp_count = 0; rst = 1'b1; nmi_n = 1'b1;
    clr(); swt_num = 7'h00; ret_level = 4'h0; cfg_en = 1'b0;
    cfg_prio = 4'h0; ret_en = 1'b1; slow = 1'b0;
    repeat (16) @(negedge clk);
    chk({br_valid, tact, flags, lvl, req}, '0);
    rst = 1'b0;
    wbr(24'h000000, 7'h00);
    tick(8);
    $display("test reset done");
    for (int r = 0; r < 4; r++)
    begin
      cfg(rows[r].idx, 1'b1, rows[r].prio);
      ev[rows[r].idx] = 1'b1;
      wbr(rows[r].vec, rows[r].tn);
      chk(ack[rows[r].idx], 1'b1);
      chk(lvl, rows[r].prio);
      tick(8);
    end
    $display("test node table done");
    for (int k = 0; k < 7; k++)
    begin
      faults = ivt_fault_t'(7'h01 << k);
      flag_clr = 8'hFF;
      v = (k == 0) ? 24'h000010 : (k == 1) ? 24'h000018 : 24'h000028;
      wbr(v, v[8:2]);
      chk(flags, 8'(8'h02 << k));
      chk(tact, 1'b1);
      tick(8);
    end
    nmi_n = 1'b0;
    wbr(24'h000008, 7'h02);
    chk(flags, 8'h81);
    nmi_n = 1'b1;
    tick(8);
    flag_clr = 8'hFF;
    nob(2);
    chk(flags, 8'h00);
    $display("test hardware traps done");
    // The return level is varied so that the restore path is exercised.
    for (int j = 0; j < 4; j++)
    begin
      swt_num = nums[j];
      swt_valid = 1'b1;
      ret_level = 4'(3 * j + 2);
      wbr({15'h0000, nums[j], 2'b00}, nums[j]);
      tick(8);
      chk(lvl, ret_level);
    end
    ret_level = 4'h0;
    sw_reset = 1'b1;
    wbr(24'h000000, 7'h00);
    tick(8);
    chk(lvl, 4'h0);
    wdt = 1'b1;
    wbr(24'h000000, 7'h00);
    tick(8);
    $display("test software traps done");
    cfg(20, 1'b0, 4'h9);
    sset[20] = 1'b1;
    nob(4);
    chk(req[20], 1'b1);
    sclr[20] = 1'b1;
    nob(2);
    chk(req[20], 1'b0);
    $display("test request flag done");
    ret_en = 1'b0;
    slow = 1'b1;
    faults.stack_under = 1'b1;
    wbr(24'h000018, 7'h06);
    ev[3] = 1'b1;
    nob(6);
    faults.stack_over = 1'b1;
    wbr(24'h000010, 7'h04);
    faults.undef_opcode = 1'b1;
    nob(4);
    ret_en = 1'b1;
    wbr(24'h000028, 7'h0A);
    wbr(24'h00006C, 7'h1B);
    tick(40);
    ret_en = 1'b0;
    nmi_n = 1'b0;
    wbr(24'h000008, 7'h02);
    nmi_n = 1'b1;
    faults.stack_over = 1'b1;
    nob(3);
    ret_en = 1'b1;
    wbr(24'h000010, 7'h04);
    tick(20);
    $display("test trap nesting done");
    ret_en = 1'b0;
    slow = 1'b0;
    ev[3] = 1'b1;
    wbr(24'h00006C, 7'h1B);
    cfg(0, 1'b1, 4'h5);
    ev[0] = 1'b1;
    nob(5);
    cfg(17, 1'b1, 4'h6);
    ev[17] = 1'b1;
    wbr(24'h00011C, 7'h47);
    chk(lvl, 4'h6);
    ret_en = 1'b1;
    wbr(24'h000060, 7'h18);
    chk(lvl, 4'h5);
    tick(30);
    $display("test preemption done");
    faults.stack_over = 1'b1;
    wbr(24'h000010, 7'h04);
    rst = 1'b1;
    tick(2);
    chk({br_valid, tact, flags, lvl}, '0);
    rst = 1'b0;
    wbr(24'h000000, 7'h00);
    $display("test second reset done");
    stop_test();
  end

  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
endmodule : tb
